// ==== logic/sea_pkg.sv ====
// Shared constants, states and carriers for the serial EEPROM access logic.
package sea_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned MEM_WORDS     = 256;
  localparam int unsigned PAGE_BYTES    = 8;
  localparam int unsigned PAGE_IDX_W    = 3;
  localparam int unsigned PAGE_NUM_W    = ADDR_W - PAGE_IDX_W;

  // Device type code compared against the control byte; the value is arbitrary.
  localparam logic [3:0]  DEV_CODE      = 4'h5;
  localparam int unsigned CODE_MSB      = 7;
  localparam int unsigned CODE_LSB      = 4;
  localparam int unsigned RW_BIT        = 0;
  localparam logic        RW_READ       = 1'h1;

  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int unsigned PROT_PAGE_BIT = PAGE_NUM_W - 1;

  // Self-timed write cycle, longest allowed time, and its cycle count at the core clock.
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned CLK_FREQ_MHZ  = 40;
  localparam int unsigned WRITE_CYC     = WRITE_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [3:0] {
    LNK_IDLE     = 4'h0,
    LNK_CTRL     = 4'h1,
    LNK_CTRL_ACK = 4'h2,
    LNK_ADDR     = 4'h3,
    LNK_ADDR_ACK = 4'h4,
    LNK_WDATA    = 4'h5,
    LNK_WDAT_ACK = 4'h6,
    LNK_RDATA    = 4'h7,
    LNK_RACK     = 4'h8,
    LNK_IGNORE   = 4'h9
  } sea_lnk_state_t;

  typedef enum logic [1:0] {
    COR_IDLE = 2'h0,
    COR_PROG = 2'h1,
    COR_WAIT = 2'h2
  } sea_cor_state_t;

  // Page handed from the link side to the core; held stable while a write cycle runs.
  typedef struct packed {
    logic [PAGE_NUM_W-1:0]     page;
    logic [PAGE_BYTES-1:0]     mask;
    logic [PAGE_BYTES-1:0][7:0] data;
  } sea_page_t;

endpackage : sea_pkg

// ==== logic/sea_sync.sv ====
// Two-stage synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/100ps

module sea_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = d_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q;

endmodule : sea_sync

// ==== logic/sea_top.sv ====
// Serial EEPROM access logic: two-wire slave on the link clock, array and write timer on the core clock.
`timescale 1ns/100ps

module sea_top #(
  parameter int unsigned T_WRITE_CYC = sea_pkg::WRITE_CYC
) (
  input  wire logic CLK_IN,
  input  wire logic SYS_RST_IN,
  input  wire logic LINK_CLK_IN,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  input  wire logic WP_IN,
  input  wire logic LOW_VCC_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE_OUT,
  output logic      WRITE_BUSY_OUT
);

  localparam int unsigned TMR_W = $clog2(T_WRITE_CYC + 1);
  localparam logic [TMR_W-1:0] WAIT_LAST = TMR_W'(T_WRITE_CYC - sea_pkg::PAGE_BYTES - 1);
  localparam logic [sea_pkg::PAGE_IDX_W-1:0] IDX_LAST = sea_pkg::PAGE_IDX_W'(sea_pkg::PAGE_BYTES - 1);

  generate
    if (T_WRITE_CYC <= sea_pkg::PAGE_BYTES + 1) begin : g_bad_cyc
      $error("T_WRITE_CYC too small for the page programming sequence.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain.

  logic       lnk_rst;
  logic       scl_s;
  logic       sda_s;
  logic       done_s;
  logic       rack_s;
  logic       done_tgl_q;
  logic       rack_tgl_q;
  logic [7:0] rdata_q;

  sea_sync #(.WIDTH(1)) u_lnk_rst (
    .clk_in (LINK_CLK_IN),
    .rst_in (1'h0),
    .d_in   (SYS_RST_IN),
    .q_out  (lnk_rst)
  );

  // Left running through reset so the edge detectors never see a false fall on release.
  sea_sync #(.WIDTH(4)) u_lnk_sync (
    .clk_in (LINK_CLK_IN),
    .rst_in (1'h0),
    .d_in   ({SCL_IN, SDA_IN, done_tgl_q, rack_tgl_q}),
    .q_out  ({scl_s, sda_s, done_s, rack_s})
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain: bus conditions, byte shifting, acknowledges, pointer and page buffer.

  sea_pkg::sea_lnk_state_t           state_q, state_d;
  logic [3:0]                        bit_cnt_q, bit_cnt_d;
  logic [7:0]                        shift_q, shift_d;
  logic [sea_pkg::ADDR_W-1:0]        ptr_q, ptr_d;
  logic [sea_pkg::ADDR_W-1:0]        rd_addr_q, rd_addr_d;
  logic                              rd_tgl_q, rd_tgl_d;
  logic                              rw_q, rw_d;
  logic                              mack_q, mack_d;
  logic                              busy_q, busy_d;
  logic                              commit_tgl_q, commit_tgl_d;
  sea_pkg::sea_page_t                pg_q, pg_d;
  logic                              oe_q, oe_d;
  logic                              scl_p_q, sda_p_q;
  logic                              done_p_q, rack_p_q;
  logic                              sda_o_q;
  logic                              rise, fall, start_c, stop_c;
  logic                              code_ok;

  assign rise    = scl_s & ~scl_p_q;
  assign fall    = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign code_ok = shift_q[sea_pkg::CODE_MSB:sea_pkg::CODE_LSB] == sea_pkg::DEV_CODE;

  always_comb begin
    state_d      = state_q;
    bit_cnt_d    = bit_cnt_q;
    shift_d      = shift_q;
    ptr_d        = ptr_q;
    rd_addr_d    = rd_addr_q;
    rd_tgl_d     = rd_tgl_q;
    rw_d         = rw_q;
    mack_d       = mack_q;
    busy_d       = busy_q;
    commit_tgl_d = commit_tgl_q;
    pg_d         = pg_q;
    oe_d         = oe_q;
    if (busy_q && (done_s != done_p_q)) begin
      busy_d = 1'h0;
    end
    if (start_c) begin
      // A repeated Start drops any unsent page but keeps the pointer.
      state_d   = sea_pkg::LNK_CTRL;
      bit_cnt_d = '0;
      oe_d      = 1'h0;
    end else if (stop_c) begin
      if ((state_q == sea_pkg::LNK_WDATA || state_q == sea_pkg::LNK_WDAT_ACK)
          && (pg_q.mask != '0) && !busy_q) begin
        commit_tgl_d = ~commit_tgl_q;
        busy_d       = 1'h1;
      end
      state_d = sea_pkg::LNK_IDLE;
      oe_d    = 1'h0;
    end else begin
      unique case (state_q)
        sea_pkg::LNK_IDLE, sea_pkg::LNK_IGNORE: begin
        end
        sea_pkg::LNK_CTRL, sea_pkg::LNK_ADDR, sea_pkg::LNK_WDATA: begin
          if (rise) begin
            shift_d   = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (fall && bit_cnt_q == sea_pkg::BYTE_BITS) begin
            bit_cnt_d = '0;
            state_d   = sea_pkg::LNK_IGNORE;
            if (busy_q) begin
              state_d = sea_pkg::LNK_IGNORE;
            end else if (state_q == sea_pkg::LNK_CTRL) begin
              if (code_ok) begin
                oe_d    = 1'h1;
                rw_d    = shift_q[sea_pkg::RW_BIT];
                state_d = sea_pkg::LNK_CTRL_ACK;
                if (shift_q[sea_pkg::RW_BIT] == sea_pkg::RW_READ) begin
                  rd_addr_d = ptr_q;
                  rd_tgl_d  = ~rd_tgl_q;
                end
              end
            end else if (state_q == sea_pkg::LNK_ADDR) begin
              ptr_d     = shift_q;
              pg_d.mask = '0;
              oe_d      = 1'h1;
              state_d   = sea_pkg::LNK_ADDR_ACK;
            end else begin
              // Low pointer bits index the buffer, so a ninth byte lands on the first.
              pg_d.data[ptr_q[sea_pkg::PAGE_IDX_W-1:0]] = shift_q;
              pg_d.mask[ptr_q[sea_pkg::PAGE_IDX_W-1:0]] = 1'h1;
              pg_d.page = ptr_q[sea_pkg::ADDR_W-1:sea_pkg::PAGE_IDX_W];
              ptr_d     = {ptr_q[sea_pkg::ADDR_W-1:sea_pkg::PAGE_IDX_W],
                           ptr_q[sea_pkg::PAGE_IDX_W-1:0] + sea_pkg::PAGE_IDX_W'(1)};
              oe_d      = 1'h1;
              state_d   = sea_pkg::LNK_WDAT_ACK;
            end
          end
        end
        sea_pkg::LNK_CTRL_ACK, sea_pkg::LNK_ADDR_ACK, sea_pkg::LNK_WDAT_ACK: begin
          if (fall) begin
            oe_d      = 1'h0;
            bit_cnt_d = '0;
            if (state_q == sea_pkg::LNK_CTRL_ACK && rw_q == sea_pkg::RW_READ) begin
              shift_d = rdata_q;
              oe_d    = ~rdata_q[7];
              ptr_d   = ptr_q + sea_pkg::ADDR_W'(1);
              state_d = sea_pkg::LNK_RDATA;
            end else if (state_q == sea_pkg::LNK_CTRL_ACK) begin
              state_d = sea_pkg::LNK_ADDR;
            end else begin
              state_d = sea_pkg::LNK_WDATA;
            end
          end
        end
        sea_pkg::LNK_RDATA: begin
          if (rise) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (fall) begin
            if (bit_cnt_q == sea_pkg::BYTE_BITS) begin
              oe_d      = 1'h0;
              bit_cnt_d = '0;
              mack_d    = 1'h0;
              state_d   = sea_pkg::LNK_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'h0};
              oe_d    = ~shift_q[6];
            end
          end
        end
        sea_pkg::LNK_RACK: begin
          if (rise) begin
            mack_d = ~sda_s;
            if (!sda_s) begin
              rd_addr_d = ptr_q;
              rd_tgl_d  = ~rd_tgl_q;
            end
          end else if (fall) begin
            if (mack_q) begin
              shift_d = rdata_q;
              oe_d    = ~rdata_q[7];
              ptr_d   = ptr_q + sea_pkg::ADDR_W'(1);
              state_d = sea_pkg::LNK_RDATA;
            end else begin
              oe_d    = 1'h0;
              state_d = sea_pkg::LNK_IGNORE;
            end
          end
        end
        default: begin
          state_d = sea_pkg::LNK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_IN) begin
    if (lnk_rst) begin
      state_q      <= sea_pkg::LNK_IDLE;
      bit_cnt_q    <= '0;
      shift_q      <= '0;
      ptr_q        <= '0;
      rd_addr_q    <= '0;
      rd_tgl_q     <= 1'h0;
      rw_q         <= 1'h0;
      mack_q       <= 1'h0;
      busy_q       <= 1'h0;
      commit_tgl_q <= 1'h0;
      pg_q         <= '0;
      oe_q         <= 1'h0;
      scl_p_q      <= 1'h1;
      sda_p_q      <= 1'h1;
      done_p_q     <= 1'h0;
      rack_p_q     <= 1'h0;
      sda_o_q      <= 1'h0;
    end else begin
      state_q      <= state_d;
      bit_cnt_q    <= bit_cnt_d;
      shift_q      <= shift_d;
      ptr_q        <= ptr_d;
      rd_addr_q    <= rd_addr_d;
      rd_tgl_q     <= rd_tgl_d;
      rw_q         <= rw_d;
      mack_q       <= mack_d;
      busy_q       <= busy_d;
      commit_tgl_q <= commit_tgl_d;
      pg_q         <= pg_d;
      oe_q         <= oe_d;
      scl_p_q      <= scl_s;
      sda_p_q      <= sda_s;
      done_p_q     <= done_s;
      rack_p_q     <= rack_s;
      sda_o_q      <= 1'h0;
    end
  end

  assign SDA_OUT    = sda_o_q;
  assign SDA_OE_OUT = oe_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Crossings into the core domain.

  logic commit_s;
  logic rd_s;
  logic wp_s;
  logic lowv_s;

  sea_sync #(.WIDTH(4)) u_cor_sync (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .d_in   ({commit_tgl_q, rd_tgl_q, WP_IN, LOW_VCC_IN}),
    .q_out  ({commit_s, rd_s, wp_s, lowv_s})
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Core domain: array, page programming and the self-timed write cycle.

  // The page carrier is held by the link side until the done toggle returns, and the read address until the next
  // read toggle, so the core samples them only after the toggle has settled.
  logic [7:0] mem [sea_pkg::MEM_WORDS];

  sea_pkg::sea_cor_state_t           cst_q, cst_d;
  logic [sea_pkg::PAGE_IDX_W-1:0]    idx_q, idx_d;
  logic [TMR_W-1:0]                  tmr_q, tmr_d;
  logic                              cbusy_q, cbusy_d;
  logic                              done_tgl_d;
  logic                              rack_tgl_d;
  logic [7:0]                        rdata_d;
  logic                              commit_p_q, rd_p_q;
  logic                              we;
  logic [sea_pkg::ADDR_W-1:0]        wa;
  logic                              allow;

  // Protection is judged per page, which matches the half boundary since pages are aligned.
  assign allow = ~lowv_s & ~(wp_s & pg_q.page[sea_pkg::PROT_PAGE_BIT]);

  always_comb begin
    cst_d      = cst_q;
    idx_d      = idx_q;
    tmr_d      = tmr_q;
    cbusy_d    = cbusy_q;
    done_tgl_d = done_tgl_q;
    rack_tgl_d = rack_tgl_q;
    rdata_d    = rdata_q;
    we         = 1'h0;
    wa         = {pg_q.page, idx_q};
    if (rd_s != rd_p_q) begin
      rdata_d    = mem[rd_addr_q];
      rack_tgl_d = ~rack_tgl_q;
    end
    unique case (cst_q)
      sea_pkg::COR_IDLE: begin
        if (commit_s != commit_p_q) begin
          cst_d   = sea_pkg::COR_PROG;
          idx_d   = '0;
          cbusy_d = 1'h1;
        end
      end
      sea_pkg::COR_PROG: begin
        we    = pg_q.mask[idx_q] & allow;
        idx_d = idx_q + sea_pkg::PAGE_IDX_W'(1);
        if (idx_q == IDX_LAST) begin
          cst_d = sea_pkg::COR_WAIT;
          tmr_d = '0;
        end
      end
      sea_pkg::COR_WAIT: begin
        tmr_d = tmr_q + TMR_W'(1);
        if (tmr_q == WAIT_LAST) begin
          cst_d      = sea_pkg::COR_IDLE;
          cbusy_d    = 1'h0;
          done_tgl_d = ~done_tgl_q;
        end
      end
      default: begin
        cst_d = sea_pkg::COR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (we) begin
      mem[wa] <= pg_q.data[idx_q];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cst_q      <= sea_pkg::COR_IDLE;
      idx_q      <= '0;
      tmr_q      <= '0;
      cbusy_q    <= 1'h0;
      done_tgl_q <= 1'h0;
      rack_tgl_q <= 1'h0;
      rdata_q    <= '0;
      commit_p_q <= 1'h0;
      rd_p_q     <= 1'h0;
    end else begin
      cst_q      <= cst_d;
      idx_q      <= idx_d;
      tmr_q      <= tmr_d;
      cbusy_q    <= cbusy_d;
      done_tgl_q <= done_tgl_d;
      rack_tgl_q <= rack_tgl_d;
      rdata_q    <= rdata_d;
      commit_p_q <= commit_s;
      rd_p_q     <= rd_s;
    end
  end

  assign WRITE_BUSY_OUT = cbusy_q;

endmodule : sea_top

// ==== tb/sea_mst.sv ====
// Behavioural two-wire bus master that drives the serial EEPROM block.
`timescale 1ns/100ps

module sea_mst (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out     = 1'h1;
    sda_low_out = 1'h0;
  end
  //////////////////////////////////////////////////
  task automatic q();
    repeat (8) @(posedge clk_in);
  endtask : q
  // Works from idle and as a repeated start from a low clock.
  task automatic start();
    q();
    sda_low_out <= 1'h0;
    q();
    scl_out <= 1'h1;
    q();
    sda_low_out <= 1'h1;
    q();
    scl_out <= 1'h0;
  endtask : start
  task automatic stop();
    q();
    sda_low_out <= 1'h1;
    q();
    scl_out <= 1'h1;
    q();
    sda_low_out <= 1'h0;
    q();
  endtask : stop
  // Clock low spans 16 link cycles so read data is ready before it is sampled.
  task automatic bit_out(input logic b);
    q();
    sda_low_out <= ~b;
    q();
    scl_out <= 1'h1;
    q();
    scl_out <= 1'h0;
  endtask : bit_out
  task automatic bit_in(output logic b);
    q();
    sda_low_out <= 1'h0;
    q();
    scl_out <= 1'h1;
    q();
    b = sda_in;
    scl_out <= 1'h0;
  endtask : bit_in
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_in(s);
      b[i] = s;
    end
    bit_out(~mack);
  endtask : rbyte
endmodule : sea_mst

// ==== tb/sea_top_chk.sv ====
// Concurrent checks on the pins of the serial EEPROM block.
`timescale 1ns/100ps

module sea_top_chk #(
  parameter int unsigned T_WRITE_CYC = 40
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic LINK_CLK_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic WRITE_BUSY_OUT
);
  logic [31:0] bcnt_q, bcnt_d;
  logic [3:0]  rcnt_q, rcnt_d;
  logic        frm_q, frm_d, scl_q, sda_q;
  //////////////////////////////////////////////////
  always_comb begin
    bcnt_d = (WRITE_BUSY_OUT && !SYS_RST_IN) ? bcnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge CLK_IN) begin
    bcnt_q <= bcnt_d;
  end
  // Rising clock edges since the last start, saturating.
  always_comb begin
    frm_d  = frm_q;
    rcnt_d = rcnt_q;
    if (!scl_q && SCL_IN && rcnt_q != 4'hf) begin
      rcnt_d = rcnt_q + 4'h1;
    end
    if (scl_q && SCL_IN && sda_q && !SDA_IN) begin
      frm_d  = 1'h1;
      rcnt_d = 4'h0;
    end
    if ((scl_q && SCL_IN && !sda_q && SDA_IN) || SYS_RST_IN) begin
      frm_d  = 1'h0;
      rcnt_d = 4'h0;
    end
  end
  always_ff @(posedge LINK_CLK_IN) begin
    scl_q  <= SCL_IN;
    sda_q  <= SDA_IN;
    frm_q  <= frm_d;
    rcnt_q <= rcnt_d;
  end
  //////////////////////////////////////////////////
  sequence s_stop;
    (SCL_IN && !SDA_IN) ##1 (SCL_IN && SDA_IN);
  endsequence
  a_sda_open: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN) !SDA_OUT)
    else $error("data pin value not low");
  a_busy_quiet: assert property (
    @(posedge LINK_CLK_IN) disable iff (SYS_RST_IN) WRITE_BUSY_OUT |-> !SDA_OE_OUT)
    else $error("data line driven while writing");
  a_oe_clk_low: assert property (
    @(posedge LINK_CLK_IN) disable iff (SYS_RST_IN) $changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("data line changed with clock high");
  a_ack_stands: assert property (
    @(posedge LINK_CLK_IN) disable iff (SYS_RST_IN) $rose(SDA_OE_OUT) |-> SDA_OE_OUT[*8])
    else $error("drive too short");
  a_stop_idle: assert property (
    @(posedge LINK_CLK_IN) disable iff (SYS_RST_IN) s_stop |=> !SDA_OE_OUT[*8])
    else $error("drive after stop");
  a_ctrl_quiet: assert property (
    @(posedge LINK_CLK_IN) disable iff (SYS_RST_IN)
    (frm_q && rcnt_q < 4'h8) |-> !SDA_OE_OUT)
    else $error("drive during control byte");
  a_busy_exact: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    $fell(WRITE_BUSY_OUT) |-> bcnt_q == T_WRITE_CYC)
    else $error("write cycle length wrong");
  a_busy_max: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN) bcnt_q <= T_WRITE_CYC)
    else $error("write cycle too long");
endmodule : sea_top_chk

bind sea_top sea_top_chk #(.T_WRITE_CYC(T_WRITE_CYC)) i_sea_top_chk (
  .CLK_IN         (CLK_IN),
  .SYS_RST_IN     (SYS_RST_IN),
  .LINK_CLK_IN    (LINK_CLK_IN),
  .SCL_IN         (SCL_IN),
  .SDA_IN         (SDA_IN),
  .SDA_OUT        (SDA_OUT),
  .SDA_OE_OUT     (SDA_OE_OUT),
  .WRITE_BUSY_OUT (WRITE_BUSY_OUT)
);

// ==== tb/sea_top_test.sv ====
// Self-checking bench for the serial EEPROM access logic.
`timescale 1ns/100ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t %s", $time, m); end end

module sea_top_test;
  // Longer than one polling control byte, so the first poll must be refused.
  localparam int unsigned T_WC = 1200;
  logic       CLK_IN      = 1'h0;
  logic       LINK_CLK_IN = 1'h0;
  logic       SYS_RST_IN  = 1'h1;
  logic       WP_IN       = 1'h0;
  logic       LOW_VCC_IN  = 1'h0;
  logic       SCL_IN, mst_low, SDA_IN, SDA_OUT, SDA_OE_OUT, WRITE_BUSY_OUT;
  logic [7:0] rbuf [0:7];
  int         err_count   = 0;
  int         comparisons = 0;
  always #12.5 CLK_IN = ~CLK_IN;
  always #40 LINK_CLK_IN = ~LINK_CLK_IN;
  assign SDA_IN = ~(SDA_OE_OUT | mst_low);
  sea_mst i_sea_mst (
    .clk_in      (LINK_CLK_IN),
    .sda_in      (SDA_IN),
    .scl_out     (SCL_IN),
    .sda_low_out (mst_low)
  );
  sea_top #(.T_WRITE_CYC(T_WC)) i_sea_top (
    .CLK_IN         (CLK_IN),
    .SYS_RST_IN     (SYS_RST_IN),
    .LINK_CLK_IN    (LINK_CLK_IN),
    .SCL_IN         (SCL_IN),
    .SDA_IN         (SDA_IN),
    .WP_IN          (WP_IN),
    .LOW_VCC_IN     (LOW_VCC_IN),
    .SDA_OUT        (SDA_OUT),
    .SDA_OE_OUT     (SDA_OE_OUT),
    .WRITE_BUSY_OUT (WRITE_BUSY_OUT)
  );
  //////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic ctrl(input logic rd, output logic ack);
    i_sea_mst.start();
    i_sea_mst.wbyte({sea_pkg::DEV_CODE, 3'h5, rd}, ack);
  endtask : ctrl
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d);
    logic ack;
    int   i;
    ctrl(1'h0, ack);
    `CHK(ack, 1'h1, "control not acked")
    i_sea_mst.wbyte(a, ack);
    `CHK(ack, 1'h1, "address not acked")
    for (i = 0; i < n; i++) begin
      i_sea_mst.wbyte(d + 8'(i), ack);
      `CHK(ack, 1'h1, "data not acked")
    end
    i_sea_mst.stop();
    for (i = 0; i < 10; i++) begin
      ctrl(1'h0, ack);
      i_sea_mst.stop();
      if (i == 0) `CHK(ack, 1'h0, "acked while writing")
      if (ack === 1'h1) break;
    end
    if (i == 10) begin
      `CHK(1'h0, 1'h1, "write never finished")
      summarize();
    end
  endtask : wr
  task automatic rd(input logic set, input logic [7:0] a, input int n);
    logic ack;
    if (set) begin
      ctrl(1'h0, ack);
      i_sea_mst.wbyte(a, ack);
    end
    ctrl(1'h1, ack);
    `CHK(ack, 1'h1, "read control not acked")
    for (int i = 0; i < n; i++) begin
      i_sea_mst.rbyte(i < n - 1, rbuf[i]);
    end
    i_sea_mst.stop();
    `CHK(SDA_IN, 1'h1, "bus not released")
  endtask : rd
  //////////////////////////////////////////////////
  task automatic t_code();
    logic ack;
    i_sea_mst.start();
    i_sea_mst.wbyte({sea_pkg::DEV_CODE ^ 4'h1, 4'h0}, ack);
    `CHK(ack, 1'h0, "foreign code acked")
    i_sea_mst.stop();
    $display("test code done");
  endtask : t_code
  task automatic t_byte();
    wr(8'h10, 2, 8'h3c);
    rd(1'h1, 8'h10, 1);
    `CHK(rbuf[0], 8'h3c, "random read")
    rd(1'h0, 8'h00, 1);
    `CHK(rbuf[0], 8'h3d, "current read")
    $display("test byte done");
  endtask : t_byte
  task automatic t_page();
    wr(8'h26, 10, 8'hd0);
    rd(1'h0, 8'h00, 8);
    for (int i = 0; i < 8; i++) begin
      `CHK(rbuf[i], 8'hd2 + 8'(i), "page byte")
    end
    $display("test page done");
  endtask : t_page
  task automatic t_prot();
    wr(8'h90, 1, 8'haa);
    @(posedge CLK_IN) WP_IN <= 1'h1;
    wr(8'h90, 1, 8'h55);
    wr(8'h12, 1, 8'h66);
    @(posedge CLK_IN) WP_IN <= 1'h0;
    LOW_VCC_IN <= 1'h1;
    wr(8'h12, 1, 8'h77);
    @(posedge CLK_IN) LOW_VCC_IN <= 1'h0;
    rd(1'h1, 8'h90, 1);
    `CHK(rbuf[0], 8'haa, "protected byte changed")
    rd(1'h1, 8'h12, 1);
    `CHK(rbuf[0], 8'h66, "lower half byte")
    $display("test protect done");
  endtask : t_prot
  task automatic t_wrap();
    wr(8'hff, 1, 8'h11);
    wr(8'h00, 1, 8'h22);
    rd(1'h1, 8'hff, 2);
    `CHK(rbuf[0], 8'h11, "top byte")
    `CHK(rbuf[1], 8'h22, "wrapped byte")
    $display("test wrap done");
  endtask : t_wrap
  // Reset spans five slow link cycles so the link side sees it too.
  initial begin
    repeat (5) @(posedge LINK_CLK_IN);
    @(posedge CLK_IN) SYS_RST_IN <= 1'h0;
    repeat (4) @(posedge LINK_CLK_IN);
    `CHK(SDA_OE_OUT | WRITE_BUSY_OUT, 1'h0, "outputs after reset")
    t_code();
    t_byte();
    t_page();
    t_prot();
    t_wrap();
    summarize();
  end
endmodule : sea_top_test
